// [src/adc_seq_pkg.sv]
// Purpose: shared constants and types for the channel sequencer
// Assumes: sixteen-bit frames, twelve-bit control word, eight inputs
// Notes:   control word sits in the first twelve bits of each frame other than a mask frame
package adc_seq_pkg;

  // frame geometry, in serial clock falling edges
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] MUX_EDGE   = 5'h0E;
  localparam int         CTRL_BITS  = 12;

  // power selections, power_sel_hi then power_sel_lo
  localparam logic [1:0] PM_NORMAL  = 2'h3;
  localparam logic [1:0] PM_FULL_SD = 2'h2;
  localparam logic [1:0] PM_AUTO_SD = 2'h1;

  // sequencer selections, sequence_enable then program bit
  localparam logic [1:0] SQ_NONE    = 2'h0;
  localparam logic [1:0] SQ_PROGRAM = 2'h1;
  localparam logic [1:0] SQ_KEEP    = 2'h2;
  localparam logic [1:0] SQ_CONSEC  = 2'h3;

  // frame buffer depth, in words
  localparam int         FIFO_DEPTH = 8;

  // reset values
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [2:0]  CHAN_RESET = 3'h0;

  // control word as received, first bit at the top
  typedef struct packed {
    logic       write_en;
    logic       sequence_enable;
    logic       spare_hi;
    logic [2:0] chan_addr;
    logic [1:0] power_sel;
    logic       seq_program;
    logic       spare_lo;
    logic       range_sel;
    logic       coding_sel;
  } ctrl_word_type;

  localparam ctrl_word_type CTRL_RESET = ctrl_word_type'(12'hC33);

  // one received frame on its way to the register stage
  typedef struct packed {
    logic        is_mask;
    logic [15:0] word;
  } frame_entry_type;

  // sequencer modes
  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_ARMED,
    MODE_MASK,
    MODE_CONSEC
  } seq_mode_type;

endpackage

// [src/adc_channel_sequencer.sv]
// Function
// [RQ1] address bits pick input as binary index
// [RQ2] both power bits one: stay fully powered
// [RQ3] one-zero: shut down, keep control contents
// [RQ4] zero-one: shut down after updating conversion
// [RQ5] host waits wake time before valid conversion
// [RQ6] host never writes both power bits zero
// [RQ7] no sequencing: convert last written address
// [RQ8] program bit: next frame loads mask
// [RQ9] any mask bit pattern is accepted
// [RQ10] enable-only write keeps sequence running
// [RQ11] both bits: channels zero through final, repeat
// [RQ12] sixteen-bit mask, write only
// [RQ13] mask loads over sixteen falling edges
// [RQ14] mask loads only after program write
// [RQ15] first bit is mask top, two halves
// [RQ16] run half one, then half two
// [RQ17] host zeroes low half for one sequence
// [RQ18] cycle ascending until non-keep write
// [RQ19] step channel on each chip select fall; code steps at the fourteenth falling edge
// [RQ20] host exits with write, both bits clear
// [RQ21] consecutive mode needs no writes
// [RQ22] write bit low leaves control unchanged
// [RQ23] mux switches on fourteenth falling edge
// [RQ24] frame: zero, address, data, zero pad
// [RQ25] sixteen clocks per frame, control first
// [RQ26] sequence starts at lowest selected channel
//
// Purpose: serial frame handling, control register and channel sequencer
// Assumes: serial clock, chip select and data in are asynchronous pins
// Notes:   frames pass an eight-word buffer before reaching control and mask registers; sequencer bits act at the mux edge
`timescale 1ns/100ps

// small synchronous fifo, flip-flop storage
module frame_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];  // storage words
  logic [AW-1:0]    wr_q;           // write index
  logic [AW-1:0]    rd_q;           // read index
  logic [AW:0]      cnt_q;          // words held

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));  // full at DEPTH words
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];

  // storage write, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // index and fill count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // frame_fifo

module adc_channel_sequencer
  import adc_seq_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        din,
  input  wire logic [11:0] sample_data,
  output logic             dout,
  output logic             dout_oe,
  output logic [2:0]       mux_chan,
  output logic             powered,
  output logic             range_sel,
  output logic             coding_sel,
  output logic             frame_drop
);

  // position p of the mask maps to bit 15-p, channel p[2:0]
  function automatic logic [3:0] next_pos(input logic [15:0] m,
                                          input logic [3:0]  p);
    logic [3:0] cand;
    logic       found;
    next_pos = p;
    found    = 1'b0;
    for (int k = 1; k <= 16; k++) begin
      cand = p + 4'(k);
      if (!found && m[4'hF - cand]) begin
        next_pos = cand;
        found    = 1'b1;
      end
    end
  endfunction

  // reset release synchroniser
  logic rst_s1_q;
  logic rst_s2_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire rst_sync_n = rst_s2_q;

  // pin synchronisers; third stage only feeds edge detection
  logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
  logic cs_s1_q, cs_s2_q, cs_s3_q;
  logic din_s1_q, din_s2_q;
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sclk_s1_q <= 1'b1;
      sclk_s2_q <= 1'b1;
      sclk_s3_q <= 1'b1;
      cs_s1_q   <= 1'b1;
      cs_s2_q   <= 1'b1;
      cs_s3_q   <= 1'b1;
      din_s1_q  <= 1'b0;
      din_s2_q  <= 1'b0;
    end else begin
      sclk_s1_q <= sclk;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      cs_s1_q   <= cs_n;
      cs_s2_q   <= cs_s1_q;
      cs_s3_q   <= cs_s2_q;
      din_s1_q  <= din;
      din_s2_q  <= din_s1_q;
    end
  end

  // frame state
  logic [4:0]      bit_cnt_q;   // falling edges seen this frame
  logic [15:0]     rx_q;        // received bits, first at top
  logic [15:0]     tx_q;        // result shifter
  logic            mask_frm_q;  // this frame loads the mask
  logic            dout_q;
  logic            dout_oe_q;
  logic            drop_q;
  // register and sequencer state
  ctrl_word_type   ctrl_q;      // control register
  logic [15:0]     mask_q;      // sequence mask, never read back
  seq_mode_type    mode_q;
  logic [3:0]      pos_q;       // mask position in sequence
  logic [2:0]      final_q;     // last channel, consecutive mode
  logic [2:0]      mux_q;       // channel for next conversion
  logic            auto_down_q; // asleep after updating conversion
  logic            powered_q;

  // edge detection and decode, all named wires
  wire cs_fall   = cs_s3_q && !cs_s2_q;
  wire cs_low    = !cs_s2_q;
  wire sclk_fall = sclk_s3_q && !sclk_s2_q;
  wire bit_take  = cs_low && sclk_fall && (bit_cnt_q < FRAME_BITS);
  wire frame_end = bit_take && (bit_cnt_q == FRAME_BITS - 5'h01);
  wire mux_edge  = bit_take && (bit_cnt_q == MUX_EDGE - 5'h01);
  // at the mux edge the control bits are rx_q[12:1]
  wire ctrl_word_type early = ctrl_word_type'(rx_q[12:1]);
  wire [1:0] early_sq = {early.sequence_enable, early.seq_program};
  wire [15:0] rx_full = {rx_q[14:0], din_s2_q};

  // frame buffer between serial side and register stage
  frame_entry_type push_entry;
  frame_entry_type pop_entry;
  logic            fifo_in_ready;
  logic            fifo_out_valid;
  wire             pop_ready = !cs_low;
  wire             pop_evt   = fifo_out_valid && pop_ready;
  wire ctrl_word_type pop_ctrl =
    ctrl_word_type'(pop_entry.word[15:16-CTRL_BITS]);
  wire [3:0] first_pos = next_pos(pop_entry.word, 4'hF);
  wire [3:0] step_pos  = next_pos(mask_q, pos_q);  // next mask position
  assign push_entry = '{is_mask: mask_frm_q, word: rx_full};
  // words only reach registers between frames; a full buffer
  // refuses the word, the serial side keeps shifting and the frame is dropped
  frame_fifo #(
    .WIDTH ($bits(frame_entry_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (sys_clk),
    .rst_n     (rst_sync_n),
    .in_data   (push_entry),
    .in_valid  (frame_end),
    .in_ready  (fifo_in_ready),
    .out_data  (pop_entry),
    .out_valid (fifo_out_valid),
    .out_ready (pop_ready)
  );

  // serial shifting; output changes on the falling edge
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bit_cnt_q <= 5'h00;
      rx_q      <= 16'h0000;
      tx_q      <= 16'h0000;
      dout_q    <= 1'b0;
      dout_oe_q <= 1'b0;
    end else begin
      dout_oe_q <= cs_low;
      if (cs_fall) begin
        // [RQ24] result framing
        // leading zero, channel, data; narrower parts pad low
        tx_q      <= {1'b0, mux_q, sample_data};
        dout_q    <= 1'b0;
        bit_cnt_q <= 5'h00;
      end else if (bit_take) begin
        // [RQ13] sixteen edge shift
        // [RQ25] frame length count
        rx_q      <= rx_full;
        tx_q      <= {tx_q[14:0], 1'b0};
        dout_q    <= tx_q[14];
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
    end
  end

  // overrun marker, one cycle per lost frame
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      drop_q <= 1'b0;
    end else begin
      drop_q <= frame_end && !fifo_in_ready;
    end
  end

  // control register and mask, loaded from the buffer
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl_q <= CTRL_RESET;
      mask_q <= MASK_RESET;
    end else if (pop_evt) begin
      if (pop_entry.is_mask) begin
        // [RQ14] mask only when armed
        // [RQ12] write-only mask
        // [RQ9] any pattern kept
        mask_q <= pop_entry.word;
      end else if (pop_ctrl.write_en) begin
        // [RQ22] write bit gate
        ctrl_q <= pop_ctrl;
      end
    end
  end

  // sequencer: mode, position and multiplexer channel
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mode_q     <= MODE_SINGLE;
      pos_q      <= 4'h0;
      final_q    <= CHAN_RESET;
      mux_q      <= CHAN_RESET;
      mask_frm_q <= 1'b0;
    end else begin
      if (cs_fall) begin
        // [RQ14] armed frame carries mask
        mask_frm_q <= (mode_q == MODE_ARMED);
      end
      if (mux_edge && !mask_frm_q && early.write_en &&
          early_sq != SQ_KEEP) begin
        // [RQ23] switch on fourteenth edge
        case (early_sq)
          SQ_NONE: begin
            // [RQ7] single channel
            // [RQ1] binary channel index
            mode_q <= MODE_SINGLE;
            mux_q  <= early.chan_addr;
          end
          SQ_PROGRAM: begin
            // [RQ8] next frame is the mask
            mode_q <= MODE_ARMED;
            mux_q  <= early.chan_addr;
          end
          SQ_CONSEC: begin
            // [RQ11] start at channel zero
            mode_q  <= MODE_CONSEC;
            final_q <= early.chan_addr;
            mux_q   <= CHAN_RESET;
          end
          default: mode_q <= mode_q;
        endcase
      end else if (mux_edge && !mask_frm_q) begin
        // [RQ10] keep-write leaves sequence alone
        // [RQ19] one step per conversion
        case (mode_q)
          MODE_MASK: begin
            // [RQ16] half one then half two
            // [RQ18] ascending, wrapping
            pos_q <= step_pos;
            mux_q <= step_pos[2:0];
          end
          MODE_CONSEC: begin
            // [RQ21] runs without writes
            mux_q <= (mux_q == final_q) ? CHAN_RESET : mux_q + 3'h1;
          end
          default: mux_q <= mux_q;
        endcase
      end else if (pop_evt && pop_entry.is_mask) begin
        // [RQ26] start at lowest selected
        // [RQ15] top bit is channel zero
        mode_q <= MODE_MASK;
        pos_q  <= first_pos;
        mux_q  <= first_pos[2:0];
      end
    end
  end

  // power state; sleep follows a conversion that updated control
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      auto_down_q <= 1'b0;
      powered_q   <= 1'b1;
    end else begin
      if (pop_evt && !pop_entry.is_mask && pop_ctrl.write_en &&
          pop_ctrl.power_sel == PM_AUTO_SD) begin
        // [RQ4] auto shutdown after update
        auto_down_q <= 1'b1;
      end else if (cs_fall) begin
        // wake on the next frame; host allows the wake time
        auto_down_q <= 1'b0;
      end
      case (ctrl_q.power_sel)
        // [RQ2] normal stays powered
        PM_NORMAL:  powered_q <= 1'b1;
        // [RQ3] full shutdown until rewritten
        PM_FULL_SD: powered_q <= 1'b0;
        PM_AUTO_SD: powered_q <= !auto_down_q;
        // invalid code: hold the last state
        default:    powered_q <= powered_q;
      endcase
    end
  end

  // outputs straight from flip-flops
  assign dout       = dout_q;
  assign dout_oe    = dout_oe_q;
  assign mux_chan   = mux_q;
  assign powered    = powered_q;
  assign range_sel  = ctrl_q.range_sel;
  assign coding_sel = ctrl_q.coding_sel;
  assign frame_drop = drop_q;
endmodule // adc_channel_sequencer

// [sim/adc_seq_asserts.sv]
// Purpose: port checks for the channel sequencer
// Assumes: serial pins reach sys_clk through two flops
// Notes:   bound from the bench top file
`timescale 1ns/100ps
module adc_seq_asserts (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       sclk,
  input wire logic       cs_n,
  input wire logic       dout,
  input wire logic       dout_oe,
  input wire logic [2:0] mux_chan,
  input wire logic       powered,
  input wire logic       range_sel,
  input wire logic       coding_sel,
  input wire logic       frame_drop
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // select held long enough to pass the synchronisers
  sequence cs_low_held;
    !cs_n [*6];
  endsequence
  sequence cs_high_held;
    cs_n [*6];
  endsequence
  // clock high in a frame, no fresh fall pending
  sequence sclk_quiet;
    (sclk && !cs_n) [*6];
  endsequence
  a_reset_state: assert property ($rose(rst_n) |-> powered && range_sel
    && coding_sel && mux_chan == 3'h0 && !dout_oe)
    else $error("outputs not at reset values");
  a_oe_in_frame: assert property (cs_low_held |-> dout_oe)
    else $error("dout_oe low inside frame");
  a_oe_idle_off: assert property (cs_high_held |-> !dout_oe)
    else $error("dout_oe high outside frame");
  a_first_bit: assert property ($rose(dout_oe) |-> !dout)
    else $error("leading bit not zero");
  a_dout_stands: assert property (sclk_quiet ##0 $past(dout_oe)
    |-> $stable(dout)) else $error("dout moved without clock fall");
  a_mux_in_frame: assert property (sclk_quiet |-> $stable(mux_chan))
    else $error("mux moved without clock fall");
  a_drop_single: assert property (frame_drop |=> !frame_drop)
    else $error("frame_drop longer than a cycle");
  a_shutdown_after: assert property ($fell(powered) |-> $past(cs_n, 4))
    else $error("power dropped inside a frame");
  a_ctrl_after: assert property ($changed({range_sel, coding_sel})
    |-> $past(cs_n, 3)) else $error("control moved inside a frame");
endmodule // adc_seq_asserts

// [sim/host_model.sv]
// Purpose: host serial port model
// Assumes: sclk idles high and stands still between frames
// Notes:   drives only at sys_clk falling edges
`timescale 1ns/100ps
module host_model (
  input  wire logic clk,
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout
);
  // idle link, nothing selected
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din  = 1'b0;
  end
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    cs_n = 1'b0;
    din  = tx[15];
    repeat (4) @(negedge clk);
    for (int i = 15; i >= 0; i--) begin
      repeat (4) @(negedge clk);
      rx[i] = dout;
      sclk  = 1'b0;
      repeat (4) @(negedge clk);
      sclk  = 1'b1;
      // released line shows no stale bit
      din   = (i > 0) ? tx[i-1] : ~tx[0];
    end
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    // gap lets the buffer drain
    repeat (8) @(negedge clk);
  endtask
endmodule // host_model

// [sim/testbench.sv]
// Purpose: self-checking bench for the channel sequencer
// Assumes: host model drives the link, 320 ns serial clock
// Notes:   each frame checks the channel and data shifted out
`timescale 1ns/100ps
module testbench;
  import adc_seq_pkg::*;
  logic        sys_clk = 1'b0;  // 25 MHz
  logic        rst_n = 1'b0;    // held low at start
  logic [11:0] sample_data = 12'h123;
  logic        sclk, cs_n, din, dout, dout_oe;
  logic        powered, range_sel, coding_sel, frame_drop;
  logic [2:0]  mux_chan;
  int          fails = 0;
  int          n_compared = 0;
  int          cycles = 0;
  logic        drop_seen = 1'b0;  // any frame lost
  always #20 sys_clk = ~sys_clk;
  host_model u_host (.clk(sys_clk), .sclk(sclk), .cs_n(cs_n), .din(din),
    .dout(dout));
  adc_channel_sequencer dut (.sys_clk(sys_clk), .rst_n(rst_n), .sclk(sclk),
    .cs_n(cs_n), .din(din), .sample_data(sample_data), .dout(dout),
    .dout_oe(dout_oe), .mux_chan(mux_chan), .powered(powered),
    .range_sel(range_sel), .coding_sel(coding_sel),
    .frame_drop(frame_drop));
  // control word, range and coding left at one
  // only valid power codes are ever passed
  function automatic logic [15:0] cw(logic [1:0] sq, logic [2:0] a,
    logic [1:0] pm);
    return {1'b1, sq[1], 1'b0, a, pm, sq[0], 3'h3, 4'h0};
  endfunction
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one transfer; frame carries zero, channel, data
  task automatic frame(logic [15:0] tx, logic [2:0] ch);
    logic [15:0] rx;
    sample_data = sample_data + 12'h111;
    u_host.xfer(tx, rx);
    chk("frame", {1'b0, ch, sample_data}, rx);
  endtask
  task automatic t_reset();
    logic [6:0] st;
    st = {mux_chan, dout_oe, powered, range_sel, coding_sel};
    chk("reset", 16'h0007, 16'(st));
  endtask
  task automatic t_single();
    logic [2:0] prev;
    prev = 3'h0;
    for (int a = 0; a < 8; a++) begin
      frame(cw(SQ_NONE, 3'(a), PM_NORMAL), prev);
      chk("mux", 16'(a), 16'(mux_chan));
      prev = 3'(a);
    end
  endtask
  task automatic t_ctrl();
    frame(16'h0000, 3'h7);
    chk("keep", 16'h0003, 16'({range_sel, coding_sel}));
    frame(16'h9F00, 3'h7);
    chk("load", 16'h0000, 16'({range_sel, coding_sel}));
  endtask
  task automatic t_power();
    frame(cw(SQ_NONE, 3'h7, PM_FULL_SD), 3'h7);
    chk("full", 16'h0000, 16'(powered));
    frame(16'h0000, 3'h7);
    chk("stay", 16'h0000, 16'(powered));
    frame(cw(SQ_NONE, 3'h7, PM_NORMAL), 3'h7);
    chk("norm", 16'h0001, 16'(powered));
    frame(cw(SQ_NONE, 3'h7, PM_AUTO_SD), 3'h7);
    chk("auto", 16'h0000, 16'(powered));
    repeat (30) @(negedge sys_clk);
    frame(cw(SQ_NONE, 3'h7, PM_NORMAL), 3'h7);
    chk("wake", 16'h0001, 16'(powered));
  endtask
  task automatic t_mask();
    frame(cw(SQ_PROGRAM, 3'h7, PM_NORMAL), 3'h7);
    frame(16'h2480, 3'h7);
    chk("first", 16'h0002, 16'(mux_chan));
    frame(16'h0000, 3'h2);
    frame(16'h0000, 3'h5);
    frame(16'h0000, 3'h0);
    frame(cw(SQ_KEEP, 3'h4, PM_NORMAL), 3'h2);
    frame(16'h0000, 3'h5);
    frame(cw(SQ_NONE, 3'h3, PM_NORMAL), 3'h0);
    // one sequence only: low half left clear
    frame(cw(SQ_PROGRAM, 3'h3, PM_NORMAL), 3'h3);
    frame(16'h4100, 3'h3);
    chk("one", 16'h0001, 16'(mux_chan));
    frame(16'h0000, 3'h1);
    frame(16'h0000, 3'h7);
    frame(cw(SQ_NONE, 3'h3, PM_NORMAL), 3'h1);
  endtask
  task automatic t_consec();
    frame(cw(SQ_CONSEC, 3'h2, PM_NORMAL), 3'h3);
    for (int i = 0; i < 4; i++) begin
      frame(16'h0000, 3'(i % 3));
    end
    frame(cw(SQ_NONE, 3'h0, PM_NORMAL), 3'h1);
    chk("exit", 16'h0000, 16'(mux_chan));
    chk("drop", 16'h0000, 16'(drop_seen));
  endtask
  task automatic print_verdict();
    if (fails == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // any lost frame is remembered for the final check
  always @(posedge sys_clk) begin
    if (frame_drop) begin
      drop_seen <= 1'b1;
    end
  end
  // hang guard, frames take about 150 cycles each
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 12000) begin
      fails++;
      print_verdict();
    end
  end
  initial begin
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    t_reset();
    t_single();
    t_ctrl();
    t_power();
    t_mask();
    t_consec();
    print_verdict();
  end
endmodule // testbench
bind adc_channel_sequencer adc_seq_asserts u_chk (.sys_clk(sys_clk),
  .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .dout(dout), .dout_oe(dout_oe),
  .mux_chan(mux_chan), .powered(powered), .range_sel(range_sel),
  .coding_sel(coding_sel), .frame_drop(frame_drop));
